//--- rss_unit.sv
// Execution unit for returns, rotates, subtracts, skips and set operations
// Function
// - Plain return pops stack top into PC, flags untouched.
// - Return with literal pops PC and loads immediate into accumulator.
// - Interrupt exit pops PC and sets global interrupt enable to one.
// - Pending interrupt at interrupt exit is serviced before main program.
// - Rotate left moves bit 7 into bit 0, flags unchanged.
// - Rotate right moves bit 0 into bit 7, flags unchanged.
// - Rotate left via carry: bit 7 to carry, old carry to bit 0.
// - Rotate right via carry: bit 0 to carry, old carry to bit 7.
// - Accumulator-target rotates write accumulator, memory byte kept.
// - Subtract with borrow is acc minus operand minus inverted carry.
// - Memory form of subtract with borrow stores into memory byte.
// - Plain subtract writes accumulator or memory byte.
// - Carry after subtract is 0 on negative, 1 on zero or positive.
// - Subtracts update wrap, zero, half, carry, signed, chained flags.
// - Decrement memory byte, write back, skip when zero.
// - Decrement to accumulator only, memory kept, skip when zero.
// - Increment memory byte, write back, skip when zero.
// - Increment to accumulator only, memory kept, skip when zero.
// - Bit test skips when the selected memory bit is one.
// - Non-zero test writes byte back and skips when non-zero.
// - Skip instructions take two cycles with a dummy cycle.
// - Byte set writes all ones, bit set forces one bit, no flags.
// - Extended skip takes three cycles on skip, two otherwise.
`timescale 1ns/1ns
`default_nettype none
`include "rss_regs.svh"
module rss_unit
    import rss_pkg::*;
#(
    parameter int PC_W = `RSS_PC_W
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             issue,
    input  wire rss_pkg::rss_op_t op,
    input  wire logic             to_acc,
    input  wire logic             use_imm,
    input  wire logic             ext,
    input  wire logic [2:0]       bit_sel,
    input  wire logic [7:0]       imm,
    input  wire logic [7:0]       mem_rdata,
    input  wire logic [PC_W-1:0]  stack_top,
    input  wire logic             irq_pending,
    input  wire logic             irq_clear,
    output logic                  ready,
    output logic                  stack_pop,
    output logic                  pc_load,
    output logic [PC_W-1:0]       pc_value,
    output logic                  skip_next,
    output logic                  irq_vector_take,
    output logic                  mem_we,
    output logic [7:0]            mem_wdata,
    output logic [7:0]            acc,
    output var rss_pkg::rss_flags_t flags,
    output logic                  global_irq_enable
);
    rss_alu_if alu_bus ();
    logic       busy;
    logic       take_skip;
    logic [7:0] opnd;
    logic [7:0] res;
    logic       res_to_acc;
    logic       res_to_mem;
    logic       is_sub;
    logic       is_skip;
    logic       new_c;
    logic       c_upd;
    logic       is_ret;
    logic       go;

    initial begin
        if (PC_W < 1) $error("rss_unit needs PC_W of at least 1");
    end

    rss_sub #(.W(`RSS_DATA_W)) u_sub (
        .a (alu_bus.alu)
    );

    rss_seq u_seq (
        .clk       (clk),
        .rst       (rst),
        .start     (go && is_skip),
        .take_skip (take_skip),
        .ext       (ext),
        .busy      (busy),
        .dummy     ()
    );

    assign ready   = ~busy;
    assign go      = issue & ~busy;
    assign opnd    = use_imm ? imm : mem_rdata;
    assign is_sub  = (op == RSS_OP_SBC) || (op == RSS_OP_SUB);
    assign is_ret  = (op == RSS_OP_RET) || (op == RSS_OP_RET_LIT) || (op == RSS_OP_IRET);
    assign is_skip = (op == RSS_OP_DECSK) || (op == RSS_OP_INCSK)
                  || (op == RSS_OP_BITSK) || (op == RSS_OP_NZSK);

    assign alu_bus.minuend    = acc;
    assign alu_bus.subtrahend = opnd;
    // Borrow is the inverse of carry; plain subtract has none
    assign alu_bus.borrow_in  = (op == RSS_OP_SBC) ? ~flags.carry : 1'b0;

    always_comb begin
        res        = opnd;
        res_to_acc = 1'b0;
        res_to_mem = 1'b0;
        take_skip  = 1'b0;
        new_c      = flags.carry;
        c_upd      = 1'b0;
        case (op)
            RSS_OP_RET_LIT: begin
                res        = imm;
                res_to_acc = 1'b1;
            end
            RSS_OP_RL: begin
                res        = {opnd[6:0], opnd[7]};
                res_to_acc = to_acc;
                res_to_mem = ~to_acc;
            end
            RSS_OP_RR: begin
                res        = {opnd[0], opnd[7:1]};
                res_to_acc = to_acc;
                res_to_mem = ~to_acc;
            end
            RSS_OP_RLC: begin
                res        = {opnd[6:0], flags.carry};
                new_c      = opnd[7];
                c_upd      = 1'b1;
                res_to_acc = to_acc;
                res_to_mem = ~to_acc;
            end
            RSS_OP_RRC: begin
                res        = {flags.carry, opnd[7:1]};
                new_c      = opnd[0];
                c_upd      = 1'b1;
                res_to_acc = to_acc;
                res_to_mem = ~to_acc;
            end
            RSS_OP_SBC, RSS_OP_SUB: begin
                res        = alu_bus.diff;
                // Immediate form always targets the accumulator
                res_to_acc = to_acc | use_imm;
                res_to_mem = ~(to_acc | use_imm);
            end
            RSS_OP_DECSK: begin
                res        = mem_rdata - `RSS_ONE;
                take_skip  = (res == 8'h00);
                res_to_acc = to_acc;
                res_to_mem = ~to_acc;
            end
            RSS_OP_INCSK: begin
                res        = mem_rdata + `RSS_ONE;
                take_skip  = (res == 8'h00);
                res_to_acc = to_acc;
                res_to_mem = ~to_acc;
            end
            RSS_OP_BITSK: begin
                take_skip = mem_rdata[bit_sel];
            end
            RSS_OP_NZSK: begin
                res        = mem_rdata;
                take_skip  = (mem_rdata != 8'h00);
                res_to_mem = 1'b1;
            end
            RSS_OP_SETB: begin
                res        = `RSS_ALL_ONES;
                res_to_mem = 1'b1;
            end
            RSS_OP_SETBIT: begin
                res          = mem_rdata;
                res[bit_sel] = 1'b1;
                res_to_mem   = 1'b1;
            end
            default: begin
                res = opnd;
            end
        endcase
    end

    // Accumulator
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc <= 8'h00;
        end else if (go && res_to_acc) begin
            acc <= res;
        end
    end

    // Memory write strobe and data, one cycle after issue
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_we    <= 1'b0;
            mem_wdata <= 8'h00;
        end else begin
            mem_we <= go && res_to_mem;
            if (go && res_to_mem) begin
                mem_wdata <= res;
            end
        end
    end

    // Status flags; rotates without carry, returns and sets leave them alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags <= '0;
        end else if (go && is_sub) begin
            flags.wrap  <= alu_bus.wrap;
            flags.zero  <= (alu_bus.diff == 8'h00);
            flags.half  <= alu_bus.half;
            flags.carry <= alu_bus.carry;
            flags.scmp  <= alu_bus.scmp;
            // Chained zero keeps a zero history across borrow chains
            flags.czero <= (alu_bus.diff == 8'h00)
                        && ((op == RSS_OP_SUB) || flags.czero);
        end else if (go && c_upd) begin
            flags.carry <= new_c;
        end
    end

    // Returns: pop and reload the PC
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stack_pop <= 1'b0;
            pc_load   <= 1'b0;
            pc_value  <= '0;
        end else begin
            stack_pop <= go && is_ret;
            pc_load   <= go && is_ret;
            if (go && is_ret) begin
                pc_value <= stack_top;
            end
        end
    end

    // Global interrupt enable; interrupt controller clears it on entry
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            global_irq_enable <= 1'b0;
        end else if (go && op == RSS_OP_IRET) begin
            global_irq_enable <= `RSS_IRQ_ON;
        end else if (irq_clear) begin
            global_irq_enable <= 1'b0;
        end
    end

    // A request waiting at interrupt exit is taken before the main code resumes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_vector_take <= 1'b0;
        end else begin
            irq_vector_take <= go && (op == RSS_OP_IRET) && irq_pending;
        end
    end

    // Skip request to the program counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            skip_next <= 1'b0;
        end else begin
            skip_next <= go && is_skip && take_skip;
        end
    end
endmodule : rss_unit
`default_nettype wire

//--- rss_regs.svh
// Constants for the rotate/subtract/skip/return execution unit
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH
`define RSS_DATA_W      8
`define RSS_PC_W        14
`define RSS_ALL_ONES    8'hff
`define RSS_ONE         8'h01
`define RSS_IRQ_ON      1'b1
`define RSS_CYC_ONE     2'h1
`define RSS_CYC_TWO     2'h2
`define RSS_CYC_THREE   2'h3
`endif

//--- rss_pkg.sv
// Types shared by the rotate/subtract/skip/return execution unit
package rss_pkg;
    typedef enum logic [4:0] {
        RSS_OP_NOP     = 5'h00,
        RSS_OP_RET     = 5'h01,
        RSS_OP_RET_LIT = 5'h02,
        RSS_OP_IRET    = 5'h03,
        RSS_OP_RL      = 5'h04,
        RSS_OP_RR      = 5'h05,
        RSS_OP_RLC     = 5'h06,
        RSS_OP_RRC     = 5'h07,
        RSS_OP_SBC     = 5'h08,
        RSS_OP_SUB     = 5'h09,
        RSS_OP_DECSK   = 5'h0a,
        RSS_OP_INCSK   = 5'h0b,
        RSS_OP_BITSK   = 5'h0c,
        RSS_OP_NZSK    = 5'h0d,
        RSS_OP_SETB    = 5'h0e,
        RSS_OP_SETBIT  = 5'h0f
    } rss_op_t;
    typedef enum logic [2:0] {
        RSS_ST_IDLE  = 3'b001,
        RSS_ST_DUMMY = 3'b010,
        RSS_ST_SKIP  = 3'b100
    } rss_state_t;
    typedef struct packed {
        logic wrap;
        logic zero;
        logic half;
        logic carry;
        logic scmp;
        logic czero;
    } rss_flags_t;
endpackage : rss_pkg

//--- rss_alu_if.sv
// Operand and result bundle between the execution unit and the subtractor
`timescale 1ns/1ns
`default_nettype none
interface rss_alu_if;
    logic [7:0] minuend;
    logic [7:0] subtrahend;
    logic       borrow_in;
    logic [7:0] diff;
    logic       wrap;
    logic       half;
    logic       carry;
    logic       scmp;
    modport core (output minuend, output subtrahend, output borrow_in,
                  input diff, input wrap, input half, input carry, input scmp);
    modport alu  (input minuend, input subtrahend, input borrow_in,
                  output diff, output wrap, output half, output carry, output scmp);
endinterface : rss_alu_if
`default_nettype wire

//--- rss_sub.sv
// Eight-bit subtractor with borrow and flag outputs
`timescale 1ns/1ns
`default_nettype none
module rss_sub #(
    parameter int W = 8
) (
    rss_alu_if.alu a
);
    logic [W:0]   full;
    logic [4:0]   low;
    logic [W-1:0] nb;
    initial begin
        if (W != 8) $error("rss_sub supports 8 bits only");
    end
    assign nb = {{(W-1){1'b0}}, a.borrow_in};
    // Modulo 256, bit W of full is the borrow out
    assign full = {1'b0, a.minuend} - {1'b0, a.subtrahend} - {1'b0, nb};
    assign low  = {1'b0, a.minuend[3:0]} - {1'b0, a.subtrahend[3:0]} - {4'h0, a.borrow_in};
    assign a.diff  = full[W-1:0];
    assign a.carry = ~full[W];
    assign a.half  = ~low[4];
    assign a.wrap  = (a.minuend[W-1] ^ a.subtrahend[W-1]) & (a.minuend[W-1] ^ full[W-1]);
    assign a.scmp  = full[W-1] ^ a.wrap;
endmodule : rss_sub
`default_nettype wire

//--- rss_seq.sv
// Skip-cycle sequencer: counts the extra cycles of a skip instruction
`timescale 1ns/1ns
`default_nettype none
module rss_seq
    import rss_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic take_skip,
    input  wire logic ext,
    output logic      busy,
    output logic      dummy
);
    rss_state_t state;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= RSS_ST_IDLE;
        end else begin
            case (state)
                RSS_ST_IDLE: begin
                    if (start) begin
                        state <= (ext && take_skip) ? RSS_ST_SKIP : RSS_ST_DUMMY;
                    end
                end
                RSS_ST_SKIP:  state <= RSS_ST_DUMMY;
                RSS_ST_DUMMY: state <= RSS_ST_IDLE;
                default:      state <= RSS_ST_IDLE;
            endcase
        end
    end
    assign busy  = (state != RSS_ST_IDLE);
    assign dummy = busy;
endmodule : rss_seq
`default_nettype wire

//--- rss_unit_asserts.sv
// Port-level assertion checker for the execution unit
`timescale 1ns/1ns
`default_nettype none
module rss_unit_asserts
    import rss_pkg::*;
#(
    parameter int PC_W = 14
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              issue,
    input wire rss_pkg::rss_op_t  op,
    input wire logic              to_acc,
    input wire logic              use_imm,
    input wire logic              ext,
    input wire logic [2:0]        bit_sel,
    input wire logic [7:0]        imm,
    input wire logic [7:0]        mem_rdata,
    input wire logic [PC_W-1:0]   stack_top,
    input wire logic              irq_pending,
    input wire logic              irq_clear,
    input wire logic              ready,
    input wire logic              stack_pop,
    input wire logic              pc_load,
    input wire logic [PC_W-1:0]   pc_value,
    input wire logic              skip_next,
    input wire logic              irq_vector_take,
    input wire logic              mem_we,
    input wire logic [7:0]        mem_wdata,
    input wire logic [7:0]        acc,
    input wire rss_pkg::rss_flags_t flags,
    input wire logic              global_irq_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire go = issue && ready;
    a_ret_pop: assert property (go && op == RSS_OP_RET |=> stack_pop && pc_load && pc_value == $past(stack_top))
        else $error("return did not pop the stack");
    a_lit_acc: assert property (go && op == RSS_OP_RET_LIT |=> pc_load && acc == $past(imm))
        else $error("literal return lost the immediate");
    a_iret_gie: assert property (go && op == RSS_OP_IRET |=> global_irq_enable && irq_vector_take == $past(irq_pending))
        else $error("interrupt exit enable or vector wrong");
    a_rot_keep: assert property (go && op inside {RSS_OP_RL, RSS_OP_RR} |=> $stable(flags))
        else $error("plain rotate touched flags");
    a_rlc_cy: assert property (go && op == RSS_OP_RLC && to_acc |=> acc == {$past(mem_rdata[6:0]), $past(flags.carry)} && flags.carry == $past(mem_rdata[7]))
        else $error("rotate via carry wrong");
    a_set_ones: assert property (go && op == RSS_OP_SETB |=> mem_we && mem_wdata == 8'hff && $stable(flags))
        else $error("byte set wrong");
    a_skip_len: assert property (go && !ext && op inside {RSS_OP_DECSK, RSS_OP_INCSK, RSS_OP_BITSK, RSS_OP_NZSK} |=> !ready ##1 ready)
        else $error("skip op length wrong");
    a_ext_len: assert property (go && ext && op == RSS_OP_DECSK && mem_rdata == 8'h01 |=> !ready [*2] ##1 ready)
        else $error("extended skip length wrong");
    a_dec_skip: assert property (go && op == RSS_OP_DECSK |=> skip_next == ($past(mem_rdata) == 8'h01))
        else $error("decrement skip decision wrong");
endmodule : rss_unit_asserts
bind rss_unit rss_unit_asserts #(.PC_W(PC_W)) u_chk (
    .clk(clk), .rst(rst), .issue(issue), .op(op), .to_acc(to_acc), .use_imm(use_imm), .ext(ext),
    .bit_sel(bit_sel), .imm(imm), .mem_rdata(mem_rdata), .stack_top(stack_top),
    .irq_pending(irq_pending), .irq_clear(irq_clear), .ready(ready), .stack_pop(stack_pop),
    .pc_load(pc_load), .pc_value(pc_value), .skip_next(skip_next), .mem_we(mem_we),
    .irq_vector_take(irq_vector_take), .mem_wdata(mem_wdata), .acc(acc), .flags(flags),
    .global_irq_enable(global_irq_enable));
`default_nettype wire

//--- rss_unit_tb.sv
// Self-checking testbench for the execution unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module rss_unit_tb;
    import rss_pkg::*;
    logic clk = 0, rst = 1, issue = 0, to_acc = 0, use_imm = 0, ext = 0, irq_pending = 0, irq_clear = 0;
    rss_op_t     op = RSS_OP_NOP;
    logic [2:0]  bit_sel = 3'h0;
    logic [7:0]  imm = 8'h00, mem_rdata = 8'h00, acc, mem_wdata;
    logic [13:0] stack_top = 14'h0000, pc_value;
    logic        ready, stack_pop, pc_load, skip_next, irq_vector_take, mem_we, global_irq_enable;
    rss_flags_t  flags;
    int          n_fail = 0, n_checks = 0;
    rss_unit DUT (.clk(clk), .rst(rst), .issue(issue), .op(op), .to_acc(to_acc), .use_imm(use_imm),
        .ext(ext), .bit_sel(bit_sel), .imm(imm), .mem_rdata(mem_rdata), .stack_top(stack_top),
        .irq_pending(irq_pending), .irq_clear(irq_clear), .ready(ready), .stack_pop(stack_pop),
        .pc_load(pc_load), .pc_value(pc_value), .skip_next(skip_next), .mem_we(mem_we),
        .irq_vector_take(irq_vector_take), .mem_wdata(mem_wdata), .acc(acc), .flags(flags),
        .global_irq_enable(global_irq_enable));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    // Starts on a fresh falling edge so issue is never driven twice in one step
    task automatic ex(input rss_op_t o, input logic ta, input logic ui, input logic e,
                      input logic [2:0] b, input logic [7:0] iv, input logic [7:0] m);
        @(negedge clk);
        op = o;
        to_acc = ta;
        use_imm = ui;
        ext = e;
        bit_sel = b;
        imm = iv;
        mem_rdata = m;
        issue = 1;
        @(posedge clk);
        @(negedge clk);
        issue = 0;
    endtask : ex
    task automatic hold(input int want);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 8) begin
            n++;
            @(negedge clk);
        end
        `CHK(n, want)
    endtask : hold
    task automatic t_ret();
        stack_top = 14'h2a5c;
        ex(RSS_OP_RET, 0, 0, 0, 0, 8'h00, 8'h00);
        `CHK({stack_pop, pc_load, pc_value, flags}, {2'b11, 14'h2a5c, 6'h00})
        stack_top = 14'h0013;
        ex(RSS_OP_RET_LIT, 0, 0, 0, 0, 8'h5a, 8'h00);
        `CHK({acc, pc_value, flags}, {8'h5a, 14'h0013, 6'h00})
        irq_pending = 1;
        ex(RSS_OP_IRET, 0, 0, 0, 0, 8'h00, 8'h00);
        `CHK({global_irq_enable, irq_vector_take}, 2'b11)
        irq_clear = 1;
        @(negedge clk);
        irq_clear = 0;
        irq_pending = 0;
        @(negedge clk);
        `CHK(global_irq_enable, 1'b0)
        irq_clear = 1;
        ex(RSS_OP_IRET, 0, 0, 0, 0, 8'h00, 8'h00);
        irq_clear = 0;
        `CHK({global_irq_enable, irq_vector_take}, 2'b10)
        $display("test ret done");
    endtask : t_ret
    task automatic t_sub();
        ex(RSS_OP_RET_LIT, 0, 0, 0, 0, 8'h10, 8'h00);
        ex(RSS_OP_SUB, 1, 0, 0, 0, 8'h00, 8'h20);
        `CHK({acc, flags.carry, flags.zero}, {8'hf0, 2'b00})
        ex(RSS_OP_SBC, 1, 1, 0, 0, 8'h01, 8'h00);
        `CHK({acc, flags.carry}, {8'hee, 1'b1})
        ex(RSS_OP_SBC, 0, 0, 0, 0, 8'h00, 8'hee);
        `CHK({mem_we, mem_wdata, acc}, {1'b1, 8'h00, 8'hee})
        `CHK({flags.zero, flags.carry, flags.czero}, 3'b110)
        ex(RSS_OP_SUB, 0, 0, 0, 0, 8'h00, 8'hee);
        `CHK({mem_we, mem_wdata, flags.czero}, {1'b1, 8'h00, 1'b1})
        ex(RSS_OP_RET_LIT, 0, 0, 0, 0, 8'h80, 8'h00);
        ex(RSS_OP_SUB, 1, 0, 0, 0, 8'h00, 8'h01);
        `CHK({acc, flags.wrap, flags.carry}, {8'h7f, 2'b11})
        $display("test sub done");
    endtask : t_sub
    task automatic t_rot();
        ex(RSS_OP_RL, 1, 0, 0, 0, 8'h00, 8'h96);
        `CHK({acc, mem_we, flags.carry}, {8'h2d, 1'b0, 1'b1})
        ex(RSS_OP_RR, 0, 0, 0, 0, 8'h00, 8'h96);
        `CHK({mem_we, mem_wdata}, {1'b1, 8'h4b})
        ex(RSS_OP_RLC, 1, 0, 0, 0, 8'h00, 8'h16);
        `CHK({acc, mem_we, flags.carry}, {8'h2d, 2'b00})
        ex(RSS_OP_RRC, 0, 0, 0, 0, 8'h00, 8'h81);
        `CHK({mem_we, mem_wdata, flags.carry}, {1'b1, 8'h40, 1'b1})
        $display("test rot done");
    endtask : t_rot
    task automatic t_skip();
        ex(RSS_OP_DECSK, 0, 0, 0, 0, 8'h00, 8'h01);
        `CHK({mem_we, mem_wdata, skip_next}, {1'b1, 8'h00, 1'b1})
        hold(1);
        ex(RSS_OP_DECSK, 1, 0, 0, 0, 8'h00, 8'h05);
        `CHK({mem_we, acc, skip_next}, {1'b0, 8'h04, 1'b0})
        hold(1);
        ex(RSS_OP_INCSK, 0, 0, 0, 0, 8'h00, 8'hff);
        `CHK({mem_we, mem_wdata, skip_next}, {1'b1, 8'h00, 1'b1})
        hold(1);
        ex(RSS_OP_INCSK, 1, 0, 0, 0, 8'h00, 8'h7f);
        `CHK({mem_we, acc, skip_next}, {1'b0, 8'h80, 1'b0})
        hold(1);
        ex(RSS_OP_BITSK, 0, 0, 0, 3'h3, 8'h00, 8'h08);
        `CHK(skip_next, 1'b1)
        hold(1);
        ex(RSS_OP_BITSK, 0, 0, 0, 3'h2, 8'h00, 8'h08);
        `CHK(skip_next, 1'b0)
        hold(1);
        ex(RSS_OP_NZSK, 0, 0, 0, 0, 8'h00, 8'h40);
        `CHK({mem_we, mem_wdata, skip_next}, {1'b1, 8'h40, 1'b1})
        hold(1);
        ex(RSS_OP_NZSK, 0, 0, 0, 0, 8'h00, 8'h00);
        `CHK(skip_next, 1'b0)
        hold(1);
        ex(RSS_OP_DECSK, 0, 0, 1, 0, 8'h00, 8'h01);
        hold(2);
        ex(RSS_OP_DECSK, 0, 0, 1, 0, 8'h00, 8'h03);
        hold(1);
        ex(RSS_OP_SETB, 0, 0, 0, 0, 8'h00, 8'h12);
        `CHK({mem_we, mem_wdata}, {1'b1, 8'hff})
        ex(RSS_OP_SETBIT, 0, 0, 0, 3'h5, 8'h00, 8'h00);
        `CHK({mem_we, mem_wdata, flags.carry}, {1'b1, 8'h20, 1'b1})
        $display("test skip done");
    endtask : t_skip
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 0;
        t_ret();
        t_sub();
        t_rot();
        t_skip();
        end_sim();
    end
    // Whole run is under a hundred cycles; this bound only catches a hang
    initial begin
        #40000;
        n_fail++;
        end_sim();
    end
endmodule : rss_unit_tb
`default_nettype wire
